// ### inc/plic_pkg.sv
// Package for the LED mode and interrupt control register bank.
// Assumes a 5-bit management register address and 16-bit registers.
`default_nettype none
package plic_pkg;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [4:0]  ADDR_LED_MODE_SELECT   = 5'h14;
   localparam logic [4:0]  ADDR_RX_ERROR_COUNTER  = 5'h15;
   localparam logic [4:0]  ADDR_INTERRUPT_CONTROL = 5'h16;
   localparam logic [4:0]  ADDR_INTERRUPT_FLAGS   = 5'h17;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_LED_MODE_SELECT    = 16'h3fe9;
   localparam logic [15:0] RST_RX_ERROR_COUNTER   = 16'h0000;
   localparam logic [15:0] RST_INTERRUPT_CONTROL  = 16'h0000;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int IND3_LSB        = 9;
   localparam int IND2_LSB        = 6;
   localparam int IND1_LSB        = 3;
   localparam int IND0_LSB        = 0;
   localparam int INT_OUT_ENABLE  = 15;
   localparam int INT_READ_CLEAR  = 14;
   localparam int INT_POLARITY    = 13;
   localparam int INT_AUTO_CLEAR  = 12;
   localparam int INT_RESETUP     = 11;
   localparam int EVENT_N         = 11;

   // ------------------------------------------------------------
   // Indicator mode codes
   // ------------------------------------------------------------
   localparam logic [2:0]  LED_LINK     = 3'h0;
   localparam logic [2:0]  LED_ACTIVITY = 3'h1;
   localparam logic [2:0]  LED_TRANSMIT = 3'h2;
   localparam logic [2:0]  LED_RECEIVE  = 3'h3;
   localparam logic [2:0]  LED_SPEED    = 3'h5;
   localparam logic [2:0]  LED_DUPLEX   = 3'h6;
   localparam logic [2:0]  LED_OFF      = 3'h7;

   // ------------------------------------------------------------
   // Management frame figures
   // ------------------------------------------------------------
   localparam logic [5:0]  PREAMBLE_ONES = 6'h20;
   localparam logic [4:0]  HEADER_LAST   = 5'h0d;
   localparam logic [4:0]  DATA_LAST     = 5'h0f;
   localparam logic [1:0]  OP_READ       = 2'h2;
   localparam logic [1:0]  OP_WRITE      = 2'h1;
   localparam logic [1:0]  FRAME_START   = 2'h1;

   // Management slave states
   typedef enum logic [3:0] {
      MS_PRE  = 4'b0001,
      MS_HDR  = 4'b0010,
      MS_TA   = 4'b0100,
      MS_DATA = 4'b1000
   } plic_mstate_e;

endpackage
`default_nettype wire

// ### hdl/plic_mdio_slave.sv
// Serial management slave: decodes read and write frames.
// Assumes MDC is far slower than clock (at least four clocks per
// half period) and that reset arrives already synchronised.
`timescale 1ns/1ps
`default_nettype none
module plic_mdio_slave
#(
   parameter int PHY_ADDR = 1
)
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rstN,
   // Management pins
   input  wire logic                mdc,
   input  wire logic                mdioIn,
   output var  logic                mdioOut,
   output var  logic                mdioOe,
   // Register access
   output var  logic [4:0]          regAddr,
   output var  logic                rdReq,
   input  wire logic [15:0]         rdData,
   output var  logic                wrReq,
   output var  logic [15:0]         wrData
);
   import plic_pkg::*;

   logic [2:0]   mdcSync;
   logic [1:0]   mdioSync;
   plic_mstate_e state,     next_state;
   logic [5:0]   preCnt,    next_preCnt;
   logic [4:0]   bitCnt,    next_bitCnt;
   logic [13:0]  hdr,       next_hdr;
   logic [15:0]  shift,     next_shift;
   logic         isRead,    next_isRead;
   logic         next_mdioOut;
   logic         next_mdioOe;
   logic [4:0]   next_regAddr;
   logic         next_rdReq;
   logic         next_wrReq;
   logic [15:0]  next_wrData;
   logic         rise;
   logic         bitIn;
   logic [13:0]  hdrIn;

   // Pin synchronisers; edge detect reads only the later stages.
   // Reset to the idle-high level so no false clock edge follows reset.
   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         mdcSync  <= 3'h7;
         mdioSync <= 2'h3;
      end
      else
      begin
         mdcSync  <= {mdcSync[1:0], mdc};
         mdioSync <= {mdioSync[0], mdioIn};
      end
   end

   assign rise  = mdcSync[1] & ~mdcSync[2];
   assign bitIn = mdioSync[1];
   assign hdrIn = {hdr[12:0], bitIn};

   // Frame sequencing on each MDC rising edge
   always_comb
   begin
      next_state   = state;
      next_preCnt  = preCnt;
      next_bitCnt  = bitCnt;
      next_hdr     = hdr;
      next_shift   = shift;
      next_isRead  = isRead;
      next_mdioOut = mdioOut;
      next_mdioOe  = mdioOe;
      next_regAddr = regAddr;
      next_rdReq   = 1'b0;
      next_wrReq   = 1'b0;
      next_wrData  = wrData;
      if (rise)
      begin
         case (state)
            MS_PRE:
            begin
               if (bitIn)
               begin
                  if (preCnt != PREAMBLE_ONES)
                     next_preCnt = preCnt + 6'h01;
               end
               else if (preCnt == PREAMBLE_ONES)
               begin
                  next_state  = MS_HDR;
                  next_hdr    = 14'h0000;
                  next_bitCnt = 5'h01;
               end
               else
                  next_preCnt = 6'h00;
            end
            MS_HDR:
            begin
               next_hdr    = hdrIn;
               next_bitCnt = bitCnt + 5'h01;
               if (bitCnt == HEADER_LAST)
               begin
                  next_bitCnt  = 5'h00;
                  next_preCnt  = 6'h00;
                  next_regAddr = hdrIn[4:0];
                  next_isRead  = (hdrIn[11:10] == OP_READ);
                  if (hdrIn[13:12] == FRAME_START &&
                      hdrIn[9:5] == 5'(PHY_ADDR) &&
                      (hdrIn[11:10] == OP_READ ||
                       hdrIn[11:10] == OP_WRITE))
                  begin
                     next_state = MS_TA;
                     next_rdReq = (hdrIn[11:10] == OP_READ);
                  end
                  else
                     next_state = MS_PRE;
               end
            end
            MS_TA:
            begin
               next_bitCnt = bitCnt + 5'h01;
               if (bitCnt == 5'h00)
               begin
                  next_shift   = rdData;
                  next_mdioOe  = isRead;
                  next_mdioOut = 1'b0;
               end
               else
               begin
                  next_state   = MS_DATA;
                  next_bitCnt  = 5'h00;
                  next_mdioOut = isRead & shift[15];
                  next_shift   = {shift[14:0], 1'b0};
               end
            end
            MS_DATA:
            begin
               next_bitCnt = bitCnt + 5'h01;
               if (isRead)
               begin
                  next_mdioOut = shift[15];
                  next_shift   = {shift[14:0], 1'b0};
               end
               else
                  next_shift = {shift[14:0], bitIn};
               if (bitCnt == DATA_LAST)
               begin
                  next_state   = MS_PRE;
                  next_mdioOe  = 1'b0;
                  next_mdioOut = 1'b0;
                  next_wrReq   = ~isRead;
                  next_wrData  = {shift[14:0], bitIn};
               end
            end
            default:
               next_state = MS_PRE;
         endcase
      end
   end

   // Frame state registers
   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         state   <= MS_PRE;
         preCnt  <= 6'h00;
         bitCnt  <= 5'h00;
         hdr     <= 14'h0000;
         shift   <= 16'h0000;
         isRead  <= 1'b0;
         mdioOut <= 1'b0;
         mdioOe  <= 1'b0;
         regAddr <= 5'h00;
         rdReq   <= 1'b0;
         wrReq   <= 1'b0;
         wrData  <= 16'h0000;
      end
      else
      begin
         state   <= next_state;
         preCnt  <= next_preCnt;
         bitCnt  <= next_bitCnt;
         hdr     <= next_hdr;
         shift   <= next_shift;
         isRead  <= next_isRead;
         mdioOut <= next_mdioOut;
         mdioOe  <= next_mdioOe;
         regAddr <= next_regAddr;
         rdReq   <= next_rdReq;
         wrReq   <= next_wrReq;
         wrData  <= next_wrData;
      end
   end

endmodule
`default_nettype wire

// ### hdl/plic_regs.sv
// Overview of operation
// RULE1 - Fourth indicator mode field, resets off
// RULE2 - Third indicator same codes, resets off
// RULE3 - Second indicator same codes, resets speed
// RULE4 - First indicator resets activity, 111 link
// RULE5 - Sixteen-bit read/write receive error count register
// RULE6 - Interrupt pin enable and active level
// RULE7 - Optional clear of flags on read
// RULE8 - Optional auto clear when condition ends
// RULE9 - Re-setup keeps written flag while condition
// RULE10 - Per-event enable bits, all reset zero
// RULE11 - Pin active when enabled flag pending
// RULE12 - Count RMII receive errors, write loads
//
// Register bank for indicator modes, receive error count and
// interrupt control, reached through the management serial pins.
// Assumes status and event inputs come from logic on clock.
`timescale 1ns/1ps
`default_nettype none
module plic_regs
#(
   parameter int PHY_ADDR = 1
)
(
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          arst_n,
   // Management pins
   input  wire logic                          mdc,
   input  wire logic                          mdioIn,
   output var  logic                          mdioOut,
   output var  logic                          mdioOe,
   // Link status from the data path
   input  wire logic                          linkUp,
   input  wire logic                          txActive,
   input  wire logic                          rxActive,
   input  wire logic                          speed100,
   input  wire logic                          fullDuplex,
   input  wire logic                          rmiiMode,
   input  wire logic                          rxErrEvent,
   // Interrupt event conditions
   input  wire logic [plic_pkg::EVENT_N-1:0]  eventCond,
   // Indicator and interrupt pins
   output var  logic                          indicatorOut3,
   output var  logic                          indicatorOut2,
   output var  logic                          indicatorOut1,
   output var  logic                          indicatorOut0,
   output var  logic                          intOut
);
   import plic_pkg::*;

   if (PHY_ADDR < 0 || PHY_ADDR > 31)
      $error("PHY_ADDR must lie in 0 to 31");

   logic [1:0]          rstSync;
   logic                rstN;
   logic [4:0]          regAddr;
   logic                rdReq;
   logic                wrReq;
   logic [15:0]         wrData;
   logic [15:0]         rdData,     next_rdData;
   logic [15:0]         ledMode,    next_ledMode;
   logic [15:0]         rxErrCount, next_rxErrCount;
   logic [15:0]         intCtl,     next_intCtl;
   logic [EVENT_N-1:0]  flags,      next_flags;
   logic [EVENT_N-1:0]  condPrev;
   logic [EVENT_N-1:0]  condRise;
   logic [EVENT_N-1:0]  flagClr;
   logic                pending;
   logic                next_intOut;
   logic                next_ind3, next_ind2, next_ind1, next_ind0;

   // ------------------------------------------------------------
   // Reset release and management slave
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         rstSync <= 2'h0;
      else
         rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   plic_mdio_slave #(.PHY_ADDR(PHY_ADDR)) uMdio
   (
      .clock   (clock),
      .rstN    (rstN),
      .mdc     (mdc),
      .mdioIn  (mdioIn),
      .mdioOut (mdioOut),
      .mdioOe  (mdioOe),
      .regAddr (regAddr),
      .rdReq   (rdReq),
      .rdData  (rdData),
      .wrReq   (wrReq),
      .wrData  (wrData)
   );

   // ------------------------------------------------------------
   // Indicator selection
   // ------------------------------------------------------------
   function automatic logic ledSel(input logic [2:0] mode,
                                   input logic       isFirst);
      case (mode)
         LED_LINK:     ledSel = linkUp;
         LED_ACTIVITY: ledSel = txActive | rxActive;
         LED_TRANSMIT: ledSel = txActive;
         LED_RECEIVE:  ledSel = rxActive;
         LED_SPEED:    ledSel = speed100;
         LED_DUPLEX:   ledSel = fullDuplex;
         LED_OFF:      ledSel = isFirst & linkUp;
         default:      ledSel = 1'b0;  // Unsupported code stays dark
      endcase
   endfunction

   // Per-indicator mode decode
   always_comb
   begin
      next_ind3 = ledSel(ledMode[IND3_LSB+:3], 1'b0);  // see RULE1
      next_ind2 = ledSel(ledMode[IND2_LSB+:3], 1'b0);  // see RULE2
      next_ind1 = ledSel(ledMode[IND1_LSB+:3], 1'b0);  // see RULE3
      next_ind0 = ledSel(ledMode[IND0_LSB+:3], 1'b1);  // see RULE4
   end

   // ------------------------------------------------------------
   // Registers, counter and flags
   // ------------------------------------------------------------
   assign condRise = eventCond & ~condPrev;

   always_comb
   begin
      next_ledMode    = ledMode;
      next_intCtl     = intCtl;
      next_rxErrCount = rxErrCount;
      next_rdData     = rdData;
      flagClr         = '0;
      if (wrReq && regAddr == ADDR_LED_MODE_SELECT)
         next_ledMode = wrData;                     // see RULE1
      if (wrReq && regAddr == ADDR_INTERRUPT_CONTROL)
         next_intCtl = wrData;                      // see RULE10
      if (wrReq && regAddr == ADDR_RX_ERROR_COUNTER)
         next_rxErrCount = wrData;                  // see RULE12
      else if (rmiiMode && rxErrEvent)
         next_rxErrCount = rxErrCount + 16'h0001;   // see RULE5
      if (rdReq && regAddr == ADDR_INTERRUPT_FLAGS && intCtl[INT_READ_CLEAR])
         flagClr = '1;                              // see RULE7
      if (wrReq && regAddr == ADDR_INTERRUPT_FLAGS)
      begin
         if (intCtl[INT_RESETUP])                   // see RULE9
            flagClr = flagClr | (wrData[EVENT_N-1:0] & ~eventCond);
         else
            flagClr = flagClr | wrData[EVENT_N-1:0];
      end
      if (intCtl[INT_AUTO_CLEAR])
         flagClr = flagClr | ~eventCond;            // see RULE8
      // A new event wins over any clear in the same cycle
      next_flags = (flags & ~flagClr) | condRise;
      if (rdReq)
      begin
         case (regAddr)
            ADDR_LED_MODE_SELECT:   next_rdData = ledMode;
            ADDR_RX_ERROR_COUNTER:  next_rdData = rxErrCount;
            ADDR_INTERRUPT_CONTROL: next_rdData = intCtl;
            ADDR_INTERRUPT_FLAGS:   next_rdData = 16'(flags);
            default:                next_rdData = 16'h0000;
         endcase
      end
   end

   // Interrupt pin level
   always_comb
   begin
      pending = |(flags & intCtl[EVENT_N-1:0]);     // see RULE10
      if (intCtl[INT_OUT_ENABLE] && pending)        // see RULE11
         next_intOut = intCtl[INT_POLARITY];        // see RULE6
      else
         next_intOut = ~intCtl[INT_POLARITY];
   end

   // State registers
   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         ledMode       <= RST_LED_MODE_SELECT;
         rxErrCount    <= RST_RX_ERROR_COUNTER;
         intCtl        <= RST_INTERRUPT_CONTROL;
         flags         <= '0;
         condPrev      <= '0;
         rdData        <= 16'h0000;
         intOut        <= 1'b1;
         indicatorOut3 <= 1'b0;
         indicatorOut2 <= 1'b0;
         indicatorOut1 <= 1'b0;
         indicatorOut0 <= 1'b0;
      end
      else
      begin
         ledMode       <= next_ledMode;
         rxErrCount    <= next_rxErrCount;
         intCtl        <= next_intCtl;
         flags         <= next_flags;
         condPrev      <= eventCond;
         rdData        <= next_rdData;
         intOut        <= next_intOut;
         indicatorOut3 <= next_ind3;
         indicatorOut2 <= next_ind2;
         indicatorOut1 <= next_ind1;
         indicatorOut0 <= next_ind0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstN);

   a_ind3_off_dark: assert property ( // see RULE1
      ledMode[IND3_LSB+:3] == LED_OFF |=> !indicatorOut3)
      else $error("Fourth indicator lit while off");
   a_ind2_speed_show: assert property ( // see RULE2
      ledMode[IND2_LSB+:3] == LED_SPEED |=> indicatorOut2 == $past(speed100))
      else $error("Third indicator does not follow speed");
   a_ind1_duplex_show: assert property ( // see RULE3
      ledMode[IND1_LSB+:3] == LED_DUPLEX
      |=> indicatorOut1 == $past(fullDuplex))
      else $error("Second indicator does not follow duplex");
   a_ind0_link_stat: assert property ( // see RULE4
      ledMode[IND0_LSB+:3] == LED_OFF |=> indicatorOut0 == $past(linkUp))
      else $error("First indicator does not show link");
   a_rxcnt_step_one: assert property ( // see RULE12
      rmiiMode && rxErrEvent &&
      !(wrReq && regAddr == ADDR_RX_ERROR_COUNTER)
      |=> rxErrCount == $past(rxErrCount) + 16'h0001)
      else $error("Receive error count did not step");
   a_rxcnt_write_load: assert property ( // see RULE5
      wrReq && regAddr == ADDR_RX_ERROR_COUNTER
      |=> rxErrCount == $past(wrData))
      else $error("Receive error count not loaded");
   a_int_pin_idle: assert property ( // see RULE6
      !intCtl[INT_OUT_ENABLE] |=> intOut != $past(intCtl[INT_POLARITY]))
      else $error("Interrupt pin active while disabled");
   a_read_clear_all: assert property ( // see RULE7
      rdReq && regAddr == ADDR_INTERRUPT_FLAGS && intCtl[INT_READ_CLEAR] &&
      condRise == '0 |=> flags == '0)
      else $error("Flags survived a clearing read");
   a_flag_sticky_hold: assert property ( // see RULE8
      flags[0] && !intCtl[INT_AUTO_CLEAR] && !rdReq && !wrReq |=> flags[0])
      else $error("Flag dropped without a clear");
   a_resetup_keep: assert property ( // see RULE9
      wrReq && regAddr == ADDR_INTERRUPT_FLAGS && intCtl[INT_RESETUP] &&
      wrData[0] && eventCond[0] && flags[0] |=> flags[0])
      else $error("Flag cleared while condition held");
   a_int_pin_active: assert property ( // see RULE11
      intCtl[INT_OUT_ENABLE] && (flags & intCtl[EVENT_N-1:0]) != '0
      |=> intOut == $past(intCtl[INT_POLARITY]))
      else $error("Interrupt pin not active");

   c_read_frame:   cover property (rdReq ##[1:1000] !mdioOe);
   c_write_frame:  cover property (wrReq && regAddr == ADDR_INTERRUPT_CONTROL);
   c_int_raised:   cover property (intCtl[INT_OUT_ENABLE] && pending);
   c_auto_cleared: cover property (flags[0] && intCtl[INT_AUTO_CLEAR]
                                   && !eventCond[0] ##1 !flags[0]);

endmodule
`default_nettype wire

// ### tb/plic_mdio_host.sv
// Station management model: drives read and write frames.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module plic_mdio_host
(
   // Clock and shared line
   input  wire logic clock,
   input  wire logic mdioWire,
   // Driven pins
   output var  logic mdc,
   output var  logic hostOut,
   output var  logic hostOe
);
   // Management clock idles high, line released
   initial
   begin
      mdc     = 1'b1;
      hostOut = 1'b1;
      hostOe  = 1'b0;
   end

   // Half a management clock period, five system clocks
   task automatic half_wait();
      repeat (5) @(posedge clock);
      #1;
   endtask

   // One slot: change data on the fall, sample on the rise
   task automatic slot(input logic oe, input logic b, output logic s);
      mdc     = 1'b0;
      hostOe  = oe;
      hostOut = b;
      half_wait();
      mdc = 1'b1;
      s   = mdioWire;
      half_wait();
   endtask

   // Whole frame with preamble; a read releases turnaround and data
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic        s;
      logic        drv;
      logic [13:0] hdr;
      hdr = {2'b01, op, phy, ra};
      drv = (op != 2'h2);
      for (int i = 0; i < 32; i++)
         slot(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--)
         slot(1'b1, hdr[i], s);
      slot(drv, 1'b1, s);
      slot(drv, 1'b0, s);
      for (int i = 15; i >= 0; i--)
      begin
         slot(drv, wd[i], s);
         rd[i] = s;
      end
      hostOe = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/phy_led_interrupt_control_tb.sv
// Bench for the indicator, error count and interrupt register bank.
// Assumes plic_mdio_host as manager and a pulled-up data line.
`timescale 1ns/1ps
`default_nettype none
module phy_led_interrupt_control_tb;
   import plic_pkg::*;
   localparam logic [4:0] PHY = 5'h01;
   logic               clock, arst_n, mdc, hostOut, hostOe;
   logic               linkUp, txActive, rxActive, speed100, fullDuplex;
   logic               rmiiMode, rxErrEvent, mdioOut, mdioOe, intOut;
   logic               ind3, ind2, ind1, ind0;
   logic [EVENT_N-1:0] eventCond;
   logic [15:0]        ledVal, r;
   logic [2:0]         c;
   int                 failCount, samplesChecked;
   wire logic          mdioWire;

   // Shared line: device, then manager, else pull-up
   assign mdioWire = mdioOe ? mdioOut : (hostOe ? hostOut : 1'b1);

   plic_regs #(.PHY_ADDR(1)) dut (.clock(clock), .arst_n(arst_n),
      .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .linkUp(linkUp), .txActive(txActive), .rxActive(rxActive),
      .speed100(speed100), .fullDuplex(fullDuplex), .rmiiMode(rmiiMode),
      .rxErrEvent(rxErrEvent), .eventCond(eventCond),
      .indicatorOut3(ind3), .indicatorOut2(ind2), .indicatorOut1(ind1),
      .indicatorOut0(ind0), .intOut(intOut));
   plic_mdio_host host (.clock(clock), .mdioWire(mdioWire), .mdc(mdc),
      .hostOut(hostOut), .hostOe(hostOe));

   // 200 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         failCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      host.frame(OP_WRITE, PHY, ra, d, r);
      tick(3);
   endtask

   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      host.frame(OP_READ, PHY, ra, 16'h0000, r);
      check(r, exp);
   endtask

   task automatic pins(input logic [3:0] e);
      check({12'h000, ind3, ind2, ind1, ind0}, {12'h000, e});
   endtask

   task automatic chkInt(input logic e);
      tick(4);
      check({15'h0000, intOut}, {15'h0000, e});
   endtask

   // Expected indicator level for a mode code
   function automatic logic lit(input logic [2:0] m, input logic first);
      case (m)
         3'h0: lit = linkUp;
         3'h1: lit = txActive | rxActive;
         3'h2: lit = txActive;
         3'h3: lit = rxActive;
         3'h5: lit = speed100;
         3'h6: lit = fullDuplex;
         3'h7: lit = first & linkUp;
         default: lit = 1'b0;
      endcase
   endfunction

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog beyond the expected run of about 266 us
   initial
   begin
      #400us;
      failCount++;
      giveVerdict();
   end

   // Main sequence
   initial
   begin
      {arst_n, linkUp, txActive, rxActive, speed100, fullDuplex} = 6'h0b;
      {rmiiMode, rxErrEvent, failCount, samplesChecked} = '0;
      eventCond = '0;
      tick(6);
      arst_n = 1'b1;
      tick(4);
      pins(4'b0011);
      chkInt(1'b1);
      rd(ADDR_LED_MODE_SELECT, 16'h3fe9);
      rd(ADDR_RX_ERROR_COUNTER, 16'h0000);
      rd(ADDR_INTERRUPT_CONTROL, 16'h0000);
      // Every code through every field, rotated per field
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         ledVal = {4'h0, c, c + 3'h1, c + 3'h2, c + 3'h3};
         wr(ADDR_LED_MODE_SELECT, ledVal);
         rd(ADDR_LED_MODE_SELECT, ledVal);
         for (int p = 0; p < 2; p++)
         begin
            {linkUp, txActive, rxActive, speed100, fullDuplex} =
               (p == 0) ? 5'b10110 : 5'b01001;
            tick(2);
            pins({lit(c, 1'b0), lit(c + 3'h1, 1'b0),
                  lit(c + 3'h2, 1'b0), lit(c + 3'h3, 1'b1)});
         end
      end
      // Counter loads, wraps, and ignores errors outside RMII
      wr(ADDR_RX_ERROR_COUNTER, 16'hfffe);
      for (int k = 0; k < 4; k++)
      begin
         {rmiiMode, rxErrEvent} = {(k < 3), 1'b1};
         tick(1);
         rxErrEvent = 1'b0;
         tick(1);
      end
      rd(ADDR_RX_ERROR_COUNTER, 16'h0001);
      // Each event: masked, then enabled, then cleared by writing 1
      for (int i = 0; i < EVENT_N; i++)
      begin
         wr(ADDR_INTERRUPT_CONTROL, 16'h8000 | (16'h07ff & ~(16'h1 << i)));
         eventCond[i] = 1'b1;
         chkInt(1'b1);
         wr(ADDR_INTERRUPT_CONTROL, 16'h8000 | (16'h1 << i));
         chkInt(1'b0);
         rd(ADDR_INTERRUPT_FLAGS, 16'h1 << i);
         eventCond[i] = 1'b0;
         wr(ADDR_INTERRUPT_FLAGS, 16'h1 << i);
         chkInt(1'b1);
      end
      // Active high; flag holds after its cause goes
      wr(ADDR_INTERRUPT_CONTROL, 16'ha001);
      chkInt(1'b0);
      eventCond[0] = 1'b1;
      tick(4);
      eventCond[0] = 1'b0;
      chkInt(1'b1);
      rd(ADDR_INTERRUPT_FLAGS, 16'h0001);
      rd(ADDR_INTERRUPT_FLAGS, 16'h0001);
      wr(ADDR_INTERRUPT_CONTROL, 16'he001);
      rd(ADDR_INTERRUPT_FLAGS, 16'h0001);
      rd(ADDR_INTERRUPT_FLAGS, 16'h0000);
      chkInt(1'b0);
      // Auto clear follows the cause
      wr(ADDR_INTERRUPT_CONTROL, 16'hb001);
      eventCond[0] = 1'b1;
      chkInt(1'b1);
      eventCond[0] = 1'b0;
      chkInt(1'b0);
      rd(ADDR_INTERRUPT_FLAGS, 16'h0000);
      // Re-setup keeps the flag while its cause stands
      wr(ADDR_INTERRUPT_CONTROL, 16'ha801);
      eventCond[0] = 1'b1;
      tick(4);
      wr(ADDR_INTERRUPT_FLAGS, 16'h0001);
      rd(ADDR_INTERRUPT_FLAGS, 16'h0001);
      // Pin disabled with a flag pending rests inactive
      wr(ADDR_INTERRUPT_CONTROL, 16'h2001);
      chkInt(1'b0);
      rd(ADDR_INTERRUPT_CONTROL, 16'h2001);
      // Unmapped read and a frame for another address
      rd(5'h1f, 16'h0000);
      host.frame(OP_WRITE, PHY + 5'h1, ADDR_LED_MODE_SELECT, 16'h0000, r);
      rd(ADDR_LED_MODE_SELECT, ledVal);
      // Reset in mid-run restores the defaults, management clock idle
      arst_n = 1'b0;
      tick(2);
      arst_n = 1'b1;
      tick(4);
      rd(ADDR_INTERRUPT_CONTROL, 16'h0000);
      rd(ADDR_LED_MODE_SELECT, 16'h3fe9);
      giveVerdict();
   end
endmodule
`default_nettype wire
